// File: pkg/dcc_pkg.sv
// Constants and types for the dual converter core clock and power configuration block
package dcc_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [15:0] DCC_OFF_CORE_PWR   = 16'h0020;
  localparam logic [15:0] DCC_OFF_WCLK_GEN   = 16'h0022;
  localparam logic [15:0] DCC_OFF_AUX_HIRES  = 16'h0024;
  localparam logic [15:0] DCC_OFF_DIVBUF_PWR = 16'h0027;
  localparam logic [15:0] DCC_OFF_SYSREF_CFG = 16'h002B;
  localparam logic [15:0] DCC_OFF_IN_DIV     = 16'h0032;
  localparam logic [15:0] DCC_OFF_A_GAIN_LO  = 16'h0037;
  localparam logic [15:0] DCC_OFF_A_GAIN_HI  = 16'h0038;
  localparam logic [15:0] DCC_OFF_B_GAIN_LO  = 16'h0039;
  localparam logic [15:0] DCC_OFF_B_GAIN_HI  = 16'h003A;
  localparam logic [15:0] DCC_OFF_A_AUX_LO   = 16'h003B;
  localparam logic [15:0] DCC_OFF_A_AUX_HI   = 16'h003C;
  localparam logic [15:0] DCC_OFF_B_AUX_LO   = 16'h003D;
  localparam logic [15:0] DCC_OFF_B_AUX_HI   = 16'h003E;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] DCC_RST_CORE_PWR   = 8'hFF;
  localparam logic [7:0] DCC_RST_WCLK_GEN   = 8'h52;
  localparam logic [7:0] DCC_RST_AUX_HIRES  = 8'hFF;
  localparam logic [7:0] DCC_RST_DIVBUF_PWR = 8'h00;
  localparam logic [7:0] DCC_RST_SYSREF_CFG = 8'h88;
  localparam logic [7:0] DCC_RST_IN_DIV     = 8'h88;
  localparam logic [7:0] DCC_RST_GAIN_LO    = 8'h20;
  localparam logic [7:0] DCC_RST_GAIN_HI    = 8'h83;
  localparam logic [7:0] DCC_RST_AUX_LO     = 8'h00;
  localparam logic [7:0] DCC_RST_AUX_HI     = 8'h82;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DCC_BIT_SEL_CLK      = 7;
  localparam int DCC_BIT_REF_PON      = 6;
  localparam int DCC_BIT_B_PON        = 3;
  localparam int DCC_BIT_A_PON        = 1;
  localparam int DCC_BIT_MON_RST      = 7;
  localparam int DCC_BIT_DET_STATE    = 6;
  localparam int DCC_BIT_WDIV_CLEAR   = 5;
  localparam int DCC_BIT_WDIV_BYP     = 3;
  localparam int DCC_BIT_AUX_HIRES    = 6;
  localparam int DCC_BIT_BUF2_PON     = 7;
  localparam int DCC_BIT_BUF1_PON     = 6;
  localparam int DCC_BIT_W_INV        = 6;
  localparam int DCC_BIT_E_INV        = 5;
  localparam int DCC_BIT_IDIV_RST     = 5;
  localparam int DCC_BIT_FREQ_RANGE   = 4;
  localparam int DCC_BIT_IDIV_BYP     = 3;
  localparam int DCC_BIT_HI_PON       = 7;
  localparam int DCC_BIT_RANGE_X2     = 2;
  localparam int DCC_MSB_RATIO        = 7;
  localparam int DCC_LSB_RATIO        = 6;
  localparam int DCC_MSB_SEL3         = 2;
  localparam int DCC_MSB_CODE_HI      = 1;

  // ****************************************************************
  // Timing: one system cycle stands for half an input clock period
  // ****************************************************************
  localparam logic [4:0] DCC_IN_HALF_CYC  = 5'h02;
  localparam logic [4:0] DCC_CNT_ONE      = 5'h01;
  localparam logic [4:0] DCC_WCNT_ONE     = 5'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dcc_req_s;

  typedef struct packed {
    logic       conv_clock_active;
    logic       reference_power_on;
    logic       chan_a_power_on;
    logic       chan_b_power_on;
    logic       aux_hires_bypass;
    logic       div_buffer2_power;
    logic       div_buffer1_power;
    logic       input_freq_range;
    logic       chan_a_gain_power;
    logic       chan_b_gain_power;
    logic       chan_a_range_double;
    logic       chan_b_range_double;
    logic [9:0] chan_a_analog_gain_code;
    logic [9:0] chan_b_analog_gain_code;
    logic       chan_a_auxconv_power;
    logic       chan_b_auxconv_power;
    logic [9:0] chan_a_auxconv_code;
    logic [9:0] chan_b_auxconv_code;
  } dcc_cfg_s;

  typedef enum logic [0:0] {
    DCC_DIV_PHASE,
    DCC_DIV_RUN
  } dcc_div_e;

endpackage

// File: verilog/dcc_core.sv
// Dual converter core clock dividers, power enables and analog code registers
`timescale 1ns/100ps
`default_nettype none
module dcc_core
  import dcc_pkg::*;
(
  input  wire logic     clk_sys_in,
  input  wire logic     rst_n_in,
  input  wire dcc_req_s reg_req_in,
  input  wire logic     west_sysref_input_in,
  input  wire logic     east_sysref_input_in,
  output var  logic [7:0] reg_rd_data_out,
  output var  logic     reg_rd_valid_out,
  output var  dcc_cfg_s cfg_out,
  output var  logic     conv_clk_en_out,
  output var  logic     word_clk_en_out,
  output var  logic     clk_mon_flag_out,
  output var  logic     divide_detector_state_out,
  output var  logic     west_sysref_out,
  output var  logic     east_sysref_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] core_pwr;
    logic [7:0] wclk_gen;
    logic [7:0] aux_hires;
    logic [7:0] divbuf_pwr;
    logic [7:0] sysref_cfg;
    logic [7:0] in_div;
    logic [7:0] a_gain_lo;
    logic [7:0] a_gain_hi;
    logic [7:0] b_gain_lo;
    logic [7:0] b_gain_hi;
    logic [7:0] a_aux_lo;
    logic [7:0] a_aux_hi;
    logic [7:0] b_aux_lo;
    logic [7:0] b_aux_hi;
    logic [7:0] rd_data;
    logic       rd_valid;
    dcc_div_e   div_state;
    logic [4:0] conv_cnt;
    logic [4:0] word_cnt;
    logic       conv_en;
    logic       word_en;
    logic       mon_flag;
    logic       det_state;
    logic [1:0] west_sync;
    logic [1:0] east_sync;
    logic       west_out;
    logic       east_out;
  } dcc_state_s;

  dcc_state_s st_reg;
  dcc_state_s st_next;

  // ****************************************************************
  // Decoders
  // ****************************************************************
  // Converter clock period in system cycles (two per input clock)
  function automatic logic [4:0] conv_period(input logic [1:0] ratio);
    case (ratio)
      2'h0:    conv_period = 5'h04;
      2'h1:    conv_period = 5'h08;
      2'h2:    conv_period = 5'h0C;
      default: conv_period = 5'h10;
    endcase
  endfunction

  function automatic logic [4:0] word_ratio(input logic [2:0] sel);
    case (sel)
      3'h0:    word_ratio = 5'h02;
      3'h1:    word_ratio = 5'h03;
      3'h2:    word_ratio = 5'h04;
      3'h3:    word_ratio = 5'h06;
      3'h4:    word_ratio = 5'h08;
      3'h5:    word_ratio = 5'h0C;
      3'h6:    word_ratio = 5'h10;
      default: word_ratio = 5'h18;
    endcase
  endfunction

  function automatic logic hit(input dcc_req_s req, input logic [15:0] off);
    hit = req.wr && (req.addr == off);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       div_restart;
    logic       conv_tick;
    logic [4:0] period;
    logic [4:0] wratio;
    div_restart = 1'b0;
    conv_tick   = 1'b0;
    period      = 5'h00;
    wratio      = 5'h00;
    st_next     = st_reg;

    // Register writes; word clock bit 7 and divider reset are actions, not storage
    if (hit(reg_req_in, DCC_OFF_CORE_PWR)) begin
      st_next.core_pwr = reg_req_in.wdata;
    end
    if (hit(reg_req_in, DCC_OFF_WCLK_GEN)) begin
      st_next.wclk_gen = {2'b00, reg_req_in.wdata[5:0]};
    end
    if (hit(reg_req_in, DCC_OFF_AUX_HIRES)) begin
      st_next.aux_hires = reg_req_in.wdata;
    end
    if (hit(reg_req_in, DCC_OFF_DIVBUF_PWR)) begin
      st_next.divbuf_pwr = {reg_req_in.wdata[7:6], 6'h00};
    end
    if (hit(reg_req_in, DCC_OFF_SYSREF_CFG)) begin
      st_next.sysref_cfg = {reg_req_in.wdata[7:5], 1'b0, reg_req_in.wdata[3:0]};
    end
    if (hit(reg_req_in, DCC_OFF_IN_DIV)) begin
      st_next.in_div = {reg_req_in.wdata[7:6], 1'b0, reg_req_in.wdata[4:0]};
      div_restart    = reg_req_in.wdata[DCC_BIT_IDIV_RST];
    end
    if (hit(reg_req_in, DCC_OFF_A_GAIN_LO)) begin
      st_next.a_gain_lo = reg_req_in.wdata;
    end
    if (hit(reg_req_in, DCC_OFF_A_GAIN_HI)) begin
      st_next.a_gain_hi = {reg_req_in.wdata[7], 4'h0, reg_req_in.wdata[2:0]};
    end
    if (hit(reg_req_in, DCC_OFF_B_GAIN_LO)) begin
      st_next.b_gain_lo = reg_req_in.wdata;
    end
    if (hit(reg_req_in, DCC_OFF_B_GAIN_HI)) begin
      st_next.b_gain_hi = {reg_req_in.wdata[7], 4'h0, reg_req_in.wdata[2:0]};
    end
    if (hit(reg_req_in, DCC_OFF_A_AUX_LO)) begin
      st_next.a_aux_lo = reg_req_in.wdata;
    end
    if (hit(reg_req_in, DCC_OFF_A_AUX_HI)) begin
      st_next.a_aux_hi = {reg_req_in.wdata[7], 5'h00, reg_req_in.wdata[1:0]};
    end
    if (hit(reg_req_in, DCC_OFF_B_AUX_LO)) begin
      st_next.b_aux_lo = reg_req_in.wdata;
    end
    if (hit(reg_req_in, DCC_OFF_B_AUX_HI)) begin
      st_next.b_aux_hi = {reg_req_in.wdata[7], 5'h00, reg_req_in.wdata[1:0]};
    end

    // Read path, one cycle after the strobe; unmapped offsets read zero
    st_next.rd_valid = reg_req_in.rd;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        DCC_OFF_CORE_PWR:   st_next.rd_data = st_reg.core_pwr;
        DCC_OFF_WCLK_GEN:   st_next.rd_data = {st_reg.mon_flag, st_reg.det_state,
                                               st_reg.wclk_gen[5:0]};
        DCC_OFF_AUX_HIRES:  st_next.rd_data = st_reg.aux_hires;
        DCC_OFF_DIVBUF_PWR: st_next.rd_data = st_reg.divbuf_pwr;
        DCC_OFF_SYSREF_CFG: st_next.rd_data = st_reg.sysref_cfg;
        DCC_OFF_IN_DIV:     st_next.rd_data = st_reg.in_div;
        DCC_OFF_A_GAIN_LO:  st_next.rd_data = st_reg.a_gain_lo;
        DCC_OFF_A_GAIN_HI:  st_next.rd_data = st_reg.a_gain_hi;
        DCC_OFF_B_GAIN_LO:  st_next.rd_data = st_reg.b_gain_lo;
        DCC_OFF_B_GAIN_HI:  st_next.rd_data = st_reg.b_gain_hi;
        DCC_OFF_A_AUX_LO:   st_next.rd_data = st_reg.a_aux_lo;
        DCC_OFF_A_AUX_HI:   st_next.rd_data = st_reg.a_aux_hi;
        DCC_OFF_B_AUX_LO:   st_next.rd_data = st_reg.b_aux_lo;
        DCC_OFF_B_AUX_HI:   st_next.rd_data = st_reg.b_aux_hi;
        default:            st_next.rd_data = 8'h00;
      endcase
    end

    // ****************************************************************
    // Converter clock: input divider with phase step and bypass
    // ****************************************************************
    period = conv_period(st_reg.in_div[DCC_MSB_RATIO:DCC_LSB_RATIO]);
    if (st_reg.in_div[DCC_BIT_IDIV_BYP]) begin
      period = DCC_IN_HALF_CYC;
    end
    if (div_restart || !st_reg.core_pwr[DCC_BIT_SEL_CLK]) begin
      // Stopped clock parks the divider so a restart begins at a known phase
      st_next.div_state = DCC_DIV_PHASE;
      st_next.conv_cnt  = 5'h00;
      st_next.word_cnt  = 5'h00;
    end else begin
      case (st_reg.div_state)
        DCC_DIV_PHASE: begin
          // Phase wait counts half input periods; bypass skips it
          if (st_reg.in_div[DCC_BIT_IDIV_BYP] ||
              st_reg.conv_cnt >= {2'b00, st_reg.in_div[DCC_MSB_SEL3:0]}) begin
            st_next.div_state = DCC_DIV_RUN;
            st_next.conv_cnt  = DCC_CNT_ONE;
            conv_tick         = 1'b1;
          end else begin
            st_next.conv_cnt = st_reg.conv_cnt + DCC_CNT_ONE;
          end
        end
        DCC_DIV_RUN: begin
          if (st_reg.conv_cnt >= period) begin
            st_next.conv_cnt = DCC_CNT_ONE;
            conv_tick        = 1'b1;
          end else begin
            st_next.conv_cnt = st_reg.conv_cnt + DCC_CNT_ONE;
          end
        end
        default: begin
          st_next.div_state = DCC_DIV_PHASE;
          st_next.conv_cnt  = 5'h00;
        end
      endcase
    end
    st_next.conv_en = conv_tick;

    // ****************************************************************
    // Word clock generator
    // ****************************************************************
    wratio          = word_ratio(st_reg.wclk_gen[DCC_MSB_SEL3:0]);
    st_next.word_en = 1'b0;
    if (st_reg.wclk_gen[DCC_BIT_WDIV_CLEAR]) begin
      st_next.word_cnt = 5'h00;
    end else if (st_reg.wclk_gen[DCC_BIT_WDIV_BYP]) begin
      st_next.word_en  = conv_tick;
      st_next.word_cnt = 5'h00;
    end else if (conv_tick && !div_restart) begin
      if (st_reg.word_cnt + DCC_WCNT_ONE >= wratio) begin
        st_next.word_cnt = 5'h00;
        st_next.word_en  = 1'b1;
      end else begin
        st_next.word_cnt = st_reg.word_cnt + DCC_WCNT_ONE;
      end
    end

    // Detector runs only while the divided word clock is really counting
    st_next.det_state = st_reg.core_pwr[DCC_BIT_SEL_CLK] &&
                        !st_reg.wclk_gen[DCC_BIT_WDIV_CLEAR] &&
                        !st_reg.wclk_gen[DCC_BIT_WDIV_BYP];

    // Monitor flag latches a stopped converter clock; a new event beats the clear
    if (!st_reg.core_pwr[DCC_BIT_SEL_CLK]) begin
      st_next.mon_flag = 1'b1;
    end else if (hit(reg_req_in, DCC_OFF_WCLK_GEN) && reg_req_in.wdata[DCC_BIT_MON_RST]) begin
      st_next.mon_flag = 1'b0;
    end

    // ****************************************************************
    // SYSREF polarity: pins pass two flip-flops before the inversion
    // ****************************************************************
    st_next.west_sync = {st_reg.west_sync[0], west_sysref_input_in};
    st_next.east_sync = {st_reg.east_sync[0], east_sysref_input_in};
    st_next.west_out  = st_reg.west_sync[1] ^ st_reg.sysref_cfg[DCC_BIT_W_INV];
    st_next.east_out  = st_reg.east_sync[1] ^ st_reg.sysref_cfg[DCC_BIT_E_INV];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st_reg            <= '0;
      st_reg.core_pwr   <= DCC_RST_CORE_PWR;
      st_reg.wclk_gen   <= DCC_RST_WCLK_GEN & 8'h3F;
      st_reg.det_state  <= DCC_RST_WCLK_GEN[DCC_BIT_DET_STATE];
      st_reg.aux_hires  <= DCC_RST_AUX_HIRES;
      st_reg.divbuf_pwr <= DCC_RST_DIVBUF_PWR;
      st_reg.sysref_cfg <= DCC_RST_SYSREF_CFG;
      st_reg.in_div     <= DCC_RST_IN_DIV;
      st_reg.a_gain_lo  <= DCC_RST_GAIN_LO;
      st_reg.a_gain_hi  <= DCC_RST_GAIN_HI;
      st_reg.b_gain_lo  <= DCC_RST_GAIN_LO;
      st_reg.b_gain_hi  <= DCC_RST_GAIN_HI;
      st_reg.a_aux_lo   <= DCC_RST_AUX_LO;
      st_reg.a_aux_hi   <= DCC_RST_AUX_HI;
      st_reg.b_aux_lo   <= DCC_RST_AUX_LO;
      st_reg.b_aux_hi   <= DCC_RST_AUX_HI;
      st_reg.div_state  <= DCC_DIV_PHASE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs, all taken directly from state flip-flops
  // ****************************************************************
  assign reg_rd_data_out                 = st_reg.rd_data;
  assign reg_rd_valid_out                = st_reg.rd_valid;
  assign conv_clk_en_out                 = st_reg.conv_en;
  assign word_clk_en_out                 = st_reg.word_en;
  assign clk_mon_flag_out                = st_reg.mon_flag;
  assign divide_detector_state_out       = st_reg.det_state;
  assign west_sysref_out                 = st_reg.west_out;
  assign east_sysref_out                 = st_reg.east_out;
  assign cfg_out.conv_clock_active       = st_reg.core_pwr[DCC_BIT_SEL_CLK];
  assign cfg_out.reference_power_on      = st_reg.core_pwr[DCC_BIT_REF_PON];
  assign cfg_out.chan_a_power_on         = st_reg.core_pwr[DCC_BIT_A_PON];
  assign cfg_out.chan_b_power_on         = st_reg.core_pwr[DCC_BIT_B_PON];
  assign cfg_out.aux_hires_bypass        = st_reg.aux_hires[DCC_BIT_AUX_HIRES];
  assign cfg_out.div_buffer2_power       = st_reg.divbuf_pwr[DCC_BIT_BUF2_PON];
  assign cfg_out.div_buffer1_power       = st_reg.divbuf_pwr[DCC_BIT_BUF1_PON];
  assign cfg_out.input_freq_range        = st_reg.in_div[DCC_BIT_FREQ_RANGE];
  assign cfg_out.chan_a_gain_power       = st_reg.a_gain_hi[DCC_BIT_HI_PON];
  assign cfg_out.chan_b_gain_power       = st_reg.b_gain_hi[DCC_BIT_HI_PON];
  assign cfg_out.chan_a_range_double     = st_reg.a_gain_hi[DCC_BIT_RANGE_X2];
  assign cfg_out.chan_b_range_double     = st_reg.b_gain_hi[DCC_BIT_RANGE_X2];
  assign cfg_out.chan_a_analog_gain_code = {st_reg.a_gain_hi[DCC_MSB_CODE_HI:0],
                                            st_reg.a_gain_lo};
  assign cfg_out.chan_b_analog_gain_code = {st_reg.b_gain_hi[DCC_MSB_CODE_HI:0],
                                            st_reg.b_gain_lo};
  assign cfg_out.chan_a_auxconv_power    = st_reg.a_aux_hi[DCC_BIT_HI_PON];
  assign cfg_out.chan_b_auxconv_power    = st_reg.b_aux_hi[DCC_BIT_HI_PON];
  assign cfg_out.chan_a_auxconv_code     = {st_reg.a_aux_hi[DCC_MSB_CODE_HI:0],
                                            st_reg.a_aux_lo};
  assign cfg_out.chan_b_auxconv_code     = {st_reg.b_aux_hi[DCC_MSB_CODE_HI:0],
                                            st_reg.b_aux_lo};

endmodule
`default_nettype wire

// File: sim/dcc_core_assertions.sv
// Port checker for the converter core clock and power block
`timescale 1ns/100ps
`default_nettype none
module dcc_core_assertions
  import dcc_pkg::*;
(
  input  wire logic     clk_sys_in,
  input  wire logic     rst_n_in,
  input  wire dcc_req_s reg_req_in,
  input  wire logic     reg_rd_valid_out,
  input  wire dcc_cfg_s cfg_out,
  input  wire logic     conv_clk_en_out,
  input  wire logic     word_clk_en_out,
  input  wire logic     clk_mon_flag_out,
  input  wire logic     divide_detector_state_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  logic clr_mon;
  logic clk_on;
  assign clr_mon = reg_req_in.wr && reg_req_in.addr == DCC_OFF_WCLK_GEN && reg_req_in.wdata[7];
  assign clk_on = cfg_out.conv_clock_active;
  property p_clk_off; !clk_on ##1 !clk_on |-> !conv_clk_en_out; endproperty
  a_clk_off: assert property (p_clk_off) else $error("converter pulse while stopped");
  property p_mon_set; !clk_on |=> clk_mon_flag_out; endproperty
  a_mon_set: assert property (p_mon_set) else $error("monitor flag not set");
  property p_mon_hold; clk_mon_flag_out && !clr_mon |=> clk_mon_flag_out; endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("monitor flag lost");
  property p_mon_clr; clr_mon && clk_on |=> !clk_mon_flag_out; endproperty
  a_mon_clr: assert property (p_mon_clr) else $error("monitor flag not cleared");
  property p_det; !clk_on |=> !divide_detector_state_out; endproperty
  a_det: assert property (p_det) else $error("detector on without clock");
  property p_gap; conv_clk_en_out |=> !conv_clk_en_out; endproperty
  a_gap: assert property (p_gap) else $error("converter faster than input");
  property p_word; word_clk_en_out |-> conv_clk_en_out; endproperty
  a_word: assert property (p_word) else $error("word pulse off converter pulse");
  property p_gain; reg_req_in.wr && reg_req_in.addr == DCC_OFF_A_GAIN_LO
    |=> cfg_out.chan_a_analog_gain_code[7:0] == $past(reg_req_in.wdata); endproperty
  a_gain: assert property (p_gain) else $error("gain low byte wrong");
  property p_ghi; reg_req_in.wr && reg_req_in.addr == DCC_OFF_B_GAIN_HI |=>
    {cfg_out.chan_b_gain_power, cfg_out.chan_b_range_double} == $past(reg_req_in.wdata[7:6])
    ^ {1'b0, $past(reg_req_in.wdata[6] ^ reg_req_in.wdata[2])}; endproperty
  a_ghi: assert property (p_ghi) else $error("gain high fields wrong");
  property p_pwr; reg_req_in.wr && reg_req_in.addr == DCC_OFF_CORE_PWR |=>
    cfg_out.chan_b_power_on == $past(reg_req_in.wdata[3]); endproperty
  a_pwr: assert property (p_pwr) else $error("channel power wrong");
  property p_rd; reg_req_in.rd |=> reg_rd_valid_out; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
endmodule
bind dcc_core dcc_core_assertions dcc_core_assertions_inst (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .reg_req_in(reg_req_in), .reg_rd_valid_out(reg_rd_valid_out),
  .cfg_out(cfg_out), .conv_clk_en_out(conv_clk_en_out), .word_clk_en_out(word_clk_en_out),
  .clk_mon_flag_out(clk_mon_flag_out),
  .divide_detector_state_out(divide_detector_state_out));
`default_nettype wire

// File: sim/test_dcc_core.sv
// Self-checking bench for the converter core clock and power block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module test_dcc_core import dcc_pkg::*;;
  logic clk_sys_in = 0, rst_n_in = 0, w_in = 0, e_in = 0, rd_valid, conv, word, mon, det;
  logic w_out, e_out;
  logic [7:0] rd_data;
  dcc_req_s req = '0;
  dcc_cfg_s cfg;
  int error_cnt = 0, total_checks = 0, n, m;
  int dv [8] = '{2, 3, 4, 6, 8, 12, 16, 24};
  logic [23:0] rt [15] = '{24'h0020FF, 24'h0024FF, 24'h002700, 24'h002B88, 24'h003288,
    24'h003720, 24'h003883, 24'h003920, 24'h003A83, 24'h003B00, 24'h003C82, 24'h003D00,
    24'h003E82, 24'h002100, 24'h002252};
  logic [31:0] wt [6] = '{32'h0027FFC0, 32'h002B7868, 32'h0038FF87, 32'h003CFF83,
    32'h003A7C04, 32'h0021FF00};
  dcc_core dcc_core_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_req_in(req),
    .west_sysref_input_in(w_in), .east_sysref_input_in(e_in), .reg_rd_data_out(rd_data),
    .reg_rd_valid_out(rd_valid), .cfg_out(cfg), .conv_clk_en_out(conv),
    .word_clk_en_out(word), .clk_mon_flag_out(mon), .divide_detector_state_out(det),
    .west_sysref_out(w_out), .east_sysref_out(e_out));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) #1 req = '{1'b1, 1'b0, a, d};
    @(posedge clk_sys_in) #1 req.wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys_in) #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys_in) #1 req.rd = 1'b0;
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_data", e, rd_data)
  endtask
  // Cycles to the next pulse, capped so a dead divider cannot hang the run
  task automatic gap(input bit wsel, output int k);
    k = 0;
    do begin
      @(posedge clk_sys_in) #1 k++;
    end while (!(wsel ? word : conv) && k < 400);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial forever #4 clk_sys_in = ~clk_sys_in;
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    foreach (rt[i]) rd_chk(rt[i][23:8], rt[i][7:0]);
    foreach (wt[i]) begin
      wr(wt[i][31:16], wt[i][15:8]);
      rd_chk(wt[i][31:16], wt[i][7:0]);
    end
    wr(16'h0037, 8'h5A);
    wr(16'h0038, 8'h82);
    `CHK("gain_a", 12'hA5A, {cfg.chan_a_gain_power, cfg.chan_a_range_double, cfg.chan_a_analog_gain_code})
    `CHK("aux_a", 1'b1, cfg.chan_a_auxconv_power)
    `CHK("buffers", 2'b11, {cfg.div_buffer2_power, cfg.div_buffer1_power})
    `CHK("gain_b", 12'h420, {cfg.chan_b_gain_power, cfg.chan_b_range_double, cfg.chan_b_analog_gain_code})
    `CHK("aux_codes", 21'h1C0200, {cfg.chan_b_auxconv_power, cfg.chan_a_auxconv_code, cfg.chan_b_auxconv_code})
    wr(16'h0024, 8'hBF);
    `CHK("aux_hires", 1'b0, cfg.aux_hires_bypass)
    wr(16'h0020, 8'hB5);
    `CHK("core_pwr", 3'b000, {cfg.reference_power_on, cfg.chan_b_power_on, cfg.chan_a_power_on})
    for (int r = 0; r < 4; r++) begin
      wr(16'h0032, 8'(r * 64 + 48));
      gap(0, n);
      gap(0, n);
      `CHK("conv_period", 4 * (r + 1), n)
    end
    `CHK("freq_range", 1'b1, cfg.input_freq_range)
    wr(16'h0032, 8'h28);
    `CHK("freq_low", 1'b0, cfg.input_freq_range)
    gap(0, n);
    gap(0, n);
    `CHK("bypass_period", 2, n)
    wr(16'h0032, 8'h20);
    gap(0, n);
    wr(16'h0032, 8'h27);
    gap(0, m);
    `CHK("phase", 7, m - n)
    wr(16'h0032, 8'h20);
    for (int i = 0; i < 9; i++) begin
      wr(16'h0022, (i == 8) ? 8'h08 : 8'(i));
      repeat (3) gap(1, n);
      `CHK("word_period", (i == 8) ? 4 : 4 * dv[i], n)
    end
    wr(16'h0022, 8'h20);
    gap(1, n);
    `CHK("word_clear", 400, n)
    `CHK("detector", 1'b0, det)
    wr(16'h0020, 8'h7F);
    gap(0, n);
    `CHK("clock_off", 400, n)
    `CHK("clk_active", 1'b0, cfg.conv_clock_active)
    wr(16'h0020, 8'hFF);
    wr(16'h0022, 8'h00);
    `CHK("mon_kept", 1'b1, mon)
    wr(16'h0022, 8'h80);
    `CHK("mon_clear", 1'b0, mon)
    `CHK("detector_on", 1'b1, det)
    rd_chk(16'h0022, 8'h40);
    wr(16'h002B, 8'h48);
    repeat (4) @(posedge clk_sys_in) #1;
    `CHK("sysref", 2'b10, {w_out, e_out})
    wr(16'h002B, 8'h28);
    w_in = 1'b1;
    e_in = 1'b1;
    repeat (4) @(posedge clk_sys_in) #1;
    `CHK("sysref_inv", 2'b10, {w_out, e_out})
    report_and_stop();
  end
endmodule
`default_nettype wire
